// >>> hdl/oag_offset_adder.sv
// Three-input 16-bit offset adder with displacement sign extension.
// Assumes unused base and index terms are presented already gated to zero; displacement is gated here by useDisp.
`timescale 1ns/1ps
`include "oag_cfg.svh"
module oag_offset_adder
  import oag_pkg::*;
(
  input logic [15:0] disp,
  input logic dispWide,
  input logic useDisp,
  input logic [15:0] baseTerm,
  input logic [15:0] indexTerm,
  output logic [15:0] offset
);
  logic [15:0] dispExt;
  logic [17:0] fullSum;
  assign dispExt = dispWide ? disp : {{8{disp[7]}}, disp[7:0]};
  assign fullSum = {2'h0, useDisp ? dispExt : 16'h0000} + {2'h0, baseTerm}
    + {2'h0, indexTerm};
  // Carries past bit 15 are dropped so the offset wraps inside the segment.
  assign offset = fullSum[15:0];
endmodule // oag_offset_adder

// >>> hdl/oag_seg_select.sv
// Segment register selection for one memory reference.
// Assumes decoder flags are stable for the cycle they are presented.
`timescale 1ns/1ps
module oag_seg_select
  import oag_pkg::*;
(
  input oag_ref_t refKind,
  input logic usesFrameBase,
  input logic altData,
  input logic overrideEn,
  input oag_seg_t overrideSeg,
  output oag_seg_t seg
);
  oag_seg_t implicitSeg;
  always_comb
  begin
    unique case (refKind)
      OAG_REF_FETCH: implicitSeg = OAG_SEG_CODE;
      OAG_REF_STACK: implicitSeg = OAG_SEG_STACK;
      OAG_REF_STR_DEST: implicitSeg = OAG_SEG_EXTRA;
      OAG_REF_DATA:
      begin
        if (usesFrameBase)
          implicitSeg = OAG_SEG_STACK;
        else if (altData)
          implicitSeg = OAG_SEG_EXTRA;
        else
          implicitSeg = OAG_SEG_DATA;
      end
    endcase
  end
  // Prefetch never honours a prefix; every other reference does.
  assign seg = (overrideEn && refKind != OAG_REF_FETCH) ? overrideSeg : implicitSeg;
endmodule // oag_seg_select

// >>> hdl/oag_top.sv
// Operand address generator: picks segment and forms offset per operand.
// Assumes the decoder presents one request per cycle with register contents.
// Functional notes
// - Memory address is a 2-bit segment identity plus 16-bit offset, 64K span.
// - Prefetch always uses the code segment, ignoring prefixes.
// - Stack pushes, pops and frame-base data references use the stack segment.
// - Other data references default to the local data segment.
// - String destinations and alternate data without a frame base use the extra segment.
// - An override prefix replaces the implicit segment.
// - Offset sums displacement, base and index as the mode requires.
// - Offset addition is 16 bits; carry out is discarded.
// - 8-bit displacement is sign extended to 16 bits.
// - Direct mode offset is the displacement alone.
// - Register indirect offset is one of two index or two base registers.
// - Based mode adds displacement and one base register.
// - Indexed mode adds displacement and one index register.
// - Based indexed mode adds base and index, no displacement.
// - Based indexed with displacement adds all three.
// - Register mode names a general register; no memory address.
// - Immediate mode takes the instruction value; no memory address.
`timescale 1ns/1ps
`include "oag_cfg.svh"
module oag_top
  import oag_pkg::*;
(
  input logic ref_clk,
  input logic rst,
  input oag_req_t req,
  input oag_regs_t regs,
  output oag_addr_t addrOut,
  output oag_opnd_t opndOut,
  output oag_state_t lastKind
);
  logic [15:0] baseTerm;
  logic [15:0] indexTerm;
  logic useDisp;
  logic usesFrameBase;
  logic isMem;
  logic [15:0] offset;
  oag_seg_t seg;
  oag_state_t next_lastKind;

  assign isMem = req.mode != OAG_MODE_REG && req.mode != OAG_MODE_IMM;

  // Term gating per addressing mode; unused terms are zero.
  always_comb
  begin
    baseTerm = 16'h0000;
    indexTerm = 16'h0000;
    useDisp = 1'b0;
    usesFrameBase = 1'b0;
    unique case (req.mode)
      OAG_MODE_REG, OAG_MODE_IMM:
      begin
        useDisp = 1'b0;
      end
      OAG_MODE_DIRECT:
      begin
        useDisp = 1'b1;
      end
      OAG_MODE_INDIRECT:
      begin
        unique case (req.indirectSel)
          OAG_IND_SRC: indexTerm = regs.srcIndex;
          OAG_IND_DEST: indexTerm = regs.destIndex;
          OAG_IND_GBASE: baseTerm = regs.generalBase;
          OAG_IND_FBASE:
          begin
            baseTerm = regs.frameBase;
            usesFrameBase = 1'b1;
          end
        endcase
      end
      OAG_MODE_BASED:
      begin
        useDisp = 1'b1;
        baseTerm = req.baseIsFrame ? regs.frameBase : regs.generalBase;
        usesFrameBase = req.baseIsFrame;
      end
      OAG_MODE_INDEXED:
      begin
        useDisp = 1'b1;
        indexTerm = req.indexIsDest ? regs.destIndex : regs.srcIndex;
      end
      OAG_MODE_BASE_IDX:
      begin
        baseTerm = req.baseIsFrame ? regs.frameBase : regs.generalBase;
        indexTerm = req.indexIsDest ? regs.destIndex : regs.srcIndex;
        usesFrameBase = req.baseIsFrame;
      end
      OAG_MODE_BASE_IDX_DISP:
      begin
        useDisp = 1'b1;
        baseTerm = req.baseIsFrame ? regs.frameBase : regs.generalBase;
        indexTerm = req.indexIsDest ? regs.destIndex : regs.srcIndex;
        usesFrameBase = req.baseIsFrame;
      end
    endcase
  end

  oag_offset_adder uAdder (
    .disp(req.disp),
    .dispWide(req.dispWide),
    .useDisp(useDisp),
    .baseTerm(baseTerm),
    .indexTerm(indexTerm),
    .offset(offset)
  );

  oag_seg_select uSeg (
    .refKind(req.refKind),
    .usesFrameBase(usesFrameBase),
    .altData(req.altData),
    .overrideEn(req.overrideEn),
    .overrideSeg(req.overrideSeg),
    .seg(seg)
  );

  // Segment and offset register together so downstream never sees a mixed pair.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      addrOut <= '0;
      addrOut.seg <= OAG_SEG_EXTRA;
    end
    else
    begin
      addrOut.valid <= req.valid && isMem;
      addrOut.isMem <= isMem;
      addrOut.seg <= seg;
      addrOut.offset <= isMem ? offset : `OAG_RST_WORD;
    end
  end

  // Non-memory operands bypass address formation entirely.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      opndOut <= '0;
    else
    begin
      opndOut.valid <= req.valid && !isMem;
      opndOut.regSel <= req.regSel;
      opndOut.regWide <= req.regWide;
      opndOut.isImm <= req.mode == OAG_MODE_IMM;
      opndOut.immValue <= req.mode == OAG_MODE_IMM ? req.immValue : `OAG_RST_WORD;
    end
  end

  always_comb
  begin
    if (!req.valid)
      next_lastKind = OAG_ST_IDLE;
    else if (req.mode == OAG_MODE_REG)
      next_lastKind = OAG_ST_REG;
    else if (req.mode == OAG_MODE_IMM)
      next_lastKind = OAG_ST_IMM;
    else
      next_lastKind = OAG_ST_MEM;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      lastKind <= OAG_ST_IDLE;
    else
      lastKind <= next_lastKind;
  end
endmodule // oag_top

// >>> pkg/oag_cfg.svh
// Constants for the operand address generator.
// Assumes inclusion by the package and design files by bare name.
`ifndef OAG_CFG_SVH
`define OAG_CFG_SVH
`define OAG_WORD_W 16
`define OAG_DISP8_W 8
`define OAG_SEG_LIMIT 32'h0001_0000
`define OAG_RST_WORD 16'h0000
`define OAG_LATENCY 1
`endif

// >>> pkg/oag_pkg.sv
// Types shared by the operand address generator modules.
// Assumes oag_cfg.svh is on the include path.
`include "oag_cfg.svh"
package oag_pkg;
  typedef enum logic [1:0] {OAG_SEG_EXTRA, OAG_SEG_CODE, OAG_SEG_STACK, OAG_SEG_DATA} oag_seg_t;
  typedef enum logic [2:0] {OAG_MODE_REG, OAG_MODE_IMM, OAG_MODE_DIRECT, OAG_MODE_INDIRECT,
    OAG_MODE_BASED, OAG_MODE_INDEXED, OAG_MODE_BASE_IDX, OAG_MODE_BASE_IDX_DISP} oag_mode_t;
  typedef enum logic [1:0] {OAG_REF_FETCH, OAG_REF_STACK, OAG_REF_DATA, OAG_REF_STR_DEST} oag_ref_t;
  typedef enum logic [1:0] {OAG_IND_SRC, OAG_IND_DEST, OAG_IND_GBASE, OAG_IND_FBASE} oag_ind_t;
  typedef enum logic [2:0] {OAG_ST_IDLE, OAG_ST_MEM, OAG_ST_REG, OAG_ST_IMM} oag_state_t;
  typedef struct packed {
    logic valid;
    oag_ref_t refKind;
    oag_mode_t mode;
    logic baseIsFrame;
    logic indexIsDest;
    oag_ind_t indirectSel;
    logic dispWide;
    logic [15:0] disp;
    logic overrideEn;
    oag_seg_t overrideSeg;
    logic altData;
    logic [3:0] regSel;
    logic regWide;
    logic [15:0] immValue;
  } oag_req_t;
  typedef struct packed {
    logic [15:0] generalBase;
    logic [15:0] frameBase;
    logic [15:0] srcIndex;
    logic [15:0] destIndex;
  } oag_regs_t;
  typedef struct packed {
    logic valid;
    logic isMem;
    oag_seg_t seg;
    logic [15:0] offset;
  } oag_addr_t;
  typedef struct packed {
    logic valid;
    logic [3:0] regSel;
    logic regWide;
    logic isImm;
    logic [15:0] immValue;
  } oag_opnd_t;
endpackage

// >>> tb/oag_sink.sv
// Model of the downstream translation stage: counts address words taken.
// Assumes it never stalls, as the block has no back-pressure.
`timescale 1ns/1ps
module oag_sink
  import oag_pkg::*;
(
  input logic ref_clk,
  input logic rst,
  input oag_addr_t addrIn,
  output int count
);
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      count <= 0;
    else if (addrIn.valid)
      count <= count + 1;
  end
endmodule // oag_sink

// >>> tb/oag_top_asserts.sv
// Port checker for the operand address generator.
// Assumes one clock, ref_clk, and a synchronous active-high rst.
`timescale 1ns/1ps
module oag_top_asserts
  import oag_pkg::*;
(
  input logic ref_clk,
  input logic rst,
  input oag_req_t req,
  input oag_regs_t regs,
  input oag_addr_t addrOut,
  input oag_opnd_t opndOut,
  input oag_state_t lastKind
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic mem;
  logic [15:0] gsSum;
  assign mem = req.valid && req.mode >= OAG_MODE_DIRECT;
  // The sum is held in 16 bits so that the wrapped value is compared.
  assign gsSum = regs.generalBase + regs.srcIndex;
  mem_valid_a: assert property (mem |=> addrOut.valid && addrOut.isMem && !opndOut.valid)
    else $error("memory request gave no address");
  fetch_code_a: assert property (mem && req.refKind == OAG_REF_FETCH
    |=> addrOut.seg == OAG_SEG_CODE) else $error("fetch not in code segment");
  data_seg_a: assert property (mem && !req.overrideEn && req.refKind == OAG_REF_DATA
    && !req.altData && req.mode inside {OAG_MODE_DIRECT, OAG_MODE_INDEXED}
    |=> addrOut.seg == OAG_SEG_DATA) else $error("data reference segment wrong");
  stack_seg_a: assert property (mem && !req.overrideEn && req.refKind == OAG_REF_STACK
    |=> addrOut.seg == OAG_SEG_STACK) else $error("stack reference segment wrong");
  str_dest_a: assert property (mem && !req.overrideEn && req.refKind == OAG_REF_STR_DEST
    |=> addrOut.seg == OAG_SEG_EXTRA) else $error("string destination segment wrong");
  seg_override_a: assert property (mem && req.overrideEn && req.refKind != OAG_REF_FETCH
    |=> addrOut.seg == $past(req.overrideSeg)) else $error("override ignored");
  direct_sext_a: assert property (mem && req.mode == OAG_MODE_DIRECT && !req.dispWide
    |=> addrOut.offset == {{8{$past(req.disp[7])}}, $past(req.disp[7:0])})
    else $error("short displacement not sign extended");
  base_idx_a: assert property (mem && req.mode == OAG_MODE_BASE_IDX && !req.baseIsFrame
    && !req.indexIsDest |=> addrOut.offset == $past(gsSum)) else $error("base plus index wrong");
  reg_opnd_a: assert property (req.valid && req.mode == OAG_MODE_REG |=> opndOut.valid
    && !opndOut.isImm && !addrOut.valid && opndOut.regSel == $past(req.regSel))
    else $error("register operand wrong");
  imm_opnd_a: assert property (req.valid && req.mode == OAG_MODE_IMM |=> opndOut.isImm
    && !addrOut.valid && opndOut.immValue == $past(req.immValue)) else $error("immediate wrong");
endmodule // oag_top_asserts
bind oag_top oag_top_asserts u_chk (.ref_clk(ref_clk), .rst(rst), .req(req), .regs(regs),
  .addrOut(addrOut), .opndOut(opndOut), .lastKind(lastKind));

// >>> tb/tb.sv
// Self-checking bench for the operand address generator.
// Assumes oag_top and the sink model; requests go back to back.
`timescale 1ns/1ps
module tb
  import oag_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  oag_req_t req = '0;
  oag_regs_t regs = '0;
  oag_addr_t addrOut;
  oag_opnd_t opndOut;
  oag_state_t lastKind;
  int sinkCount;
  int badCount = 0;
  int cmpCount = 0;
  int memCount = 0;
  logic [31:0] seed = 32'h3280ABE1;
  always #12.5 ref_clk = ~ref_clk;
  oag_top u_dut (.ref_clk(ref_clk), .rst(rst), .req(req), .regs(regs), .addrOut(addrOut),
    .opndOut(opndOut), .lastKind(lastKind));
  oag_sink u_sink (.ref_clk(ref_clk), .rst(rst), .addrIn(addrOut), .count(sinkCount));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      badCount++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic oag_seg_t eseg(oag_req_t r);
    logic fb;
    fb = r.baseIsFrame && r.mode inside {OAG_MODE_BASED, OAG_MODE_BASE_IDX,
      OAG_MODE_BASE_IDX_DISP};
    fb |= r.mode == OAG_MODE_INDIRECT && r.indirectSel == OAG_IND_FBASE;
    if (r.refKind == OAG_REF_FETCH)
      return OAG_SEG_CODE;
    if (r.overrideEn)
      return r.overrideSeg;
    // A string destination keeps the extra segment even when a frame-base operand is named.
    if (r.refKind == OAG_REF_STR_DEST)
      return OAG_SEG_EXTRA;
    if (r.refKind == OAG_REF_STACK || fb)
      return OAG_SEG_STACK;
    if (r.altData)
      return OAG_SEG_EXTRA;
    return OAG_SEG_DATA;
  endfunction
  function automatic logic [15:0] eoff(oag_req_t r, oag_regs_t g);
    logic [15:0] b, x, d;
    logic [15:0] ind [4];
    b = r.baseIsFrame ? g.frameBase : g.generalBase;
    x = r.indexIsDest ? g.destIndex : g.srcIndex;
    d = r.dispWide ? r.disp : {{8{r.disp[7]}}, r.disp[7:0]};
    ind = '{g.srcIndex, g.destIndex, g.generalBase, g.frameBase};
    case (r.mode)
      OAG_MODE_DIRECT: return d;
      OAG_MODE_INDIRECT: return ind[r.indirectSel];
      OAG_MODE_BASED: return d + b;
      OAG_MODE_INDEXED: return d + x;
      OAG_MODE_BASE_IDX: return b + x;
      default: return b + x + d;
    endcase
  endfunction
  task automatic check_out(oag_req_t r, oag_regs_t g);
    logic mem;
    mem = r.valid && r.mode >= OAG_MODE_DIRECT;
    memCount += mem;
    chk(addrOut.valid, mem);
    chk(opndOut.valid, r.valid && !mem);
    chk(lastKind, !r.valid ? OAG_ST_IDLE : mem ? OAG_ST_MEM :
      r.mode == OAG_MODE_REG ? OAG_ST_REG : OAG_ST_IMM);
    if (mem)
    begin
      chk(addrOut.seg, eseg(r));
      chk(addrOut.offset, eoff(r, g));
    end
    if (r.valid && r.mode == OAG_MODE_IMM)
      chk(opndOut.immValue, r.immValue);
    if (r.valid && r.mode == OAG_MODE_REG)
      chk({opndOut.regWide, opndOut.regSel}, {r.regWide, r.regSel});
  endtask
  task automatic finalReport();
    $display("Compares %0d, mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    oag_req_t r, pr;
    oag_regs_t g, pg;
    logic [63:0] w;
    pr = '0;
    pg = '0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk(addrOut, 0);
    chk(opndOut, 0);
    chk(lastKind, OAG_ST_IDLE);
    $display("Reset test done");
    for (int i = 0; i < 401; i++)
    begin
      w = {xs(), xs()};
      r = w[$bits(oag_req_t)-1:0];
      g = {xs(), xs()};
      // The first two are wraparound corners: frame base near the top, negative short offset.
      if (i < 2)
      begin
        r = '0;
        r.valid = 1'b1;
        r.refKind = OAG_REF_DATA;
        r.mode = i == 0 ? OAG_MODE_BASED : OAG_MODE_BASE_IDX_DISP;
        r.baseIsFrame = i == 0;
        r.disp = i == 0 ? 16'h0020 : 16'h0080;
        g.frameBase = 16'hFFF0;
      end
      if (i == 400)
        r = '0;
      @(posedge ref_clk);
      req <= r;
      regs <= g;
      #1;
      check_out(pr, pg);
      pr = r;
      pg = g;
    end
    // The sink counts a word one edge after it appears, so the last word needs one more edge.
    @(posedge ref_clk);
    #1;
    chk(sinkCount, memCount);
    $display("Random test done");
    finalReport();
  end
endmodule // tb
